// File: bca_pkg.sv
/*
 Constants, register map and cipher arithmetic of the accelerator.
 Assumes a 32-bit register port with byte addresses.
*/
// Operation
// - Encrypt 128-bit plaintext with key; decrypt 128-bit ciphertext back.
// - One block completes unaided about 1000 clocks after its input.
// - Data moves through the processor data port or the DMA port.
// - Control bit 0 selects direction: 1 decrypt, 0 encrypt.
// - Four data port writes form one 128-bit input block.
// - Result is read from the data port in four successive reads.
// - Input-needed bit is read-only and clears after the fourth write.
// - Output-ready bit sets at completion, clears after the fourth read.
// - Bit 1 high while input awaited; bit 2 high while output ready.
// - Chaining off after reset: result depends on block and key alone.
// - Control bit 7 enables chaining on the previous ciphertext block.
`default_nettype none
package bca_pkg;

    localparam int unsigned ADDR_W       = 12;
    localparam logic [11:0] CTRL_OFS     = 12'h540;
    localparam logic [11:0] DATA_OFS     = 12'h548;
    localparam logic [11:0] KEY_OFS      = 12'h550;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h560;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h564;

    localparam int unsigned CTRL_DEC_BIT  = 0;
    localparam int unsigned CTRL_NEED_BIT = 1;
    localparam int unsigned CTRL_RDY_BIT  = 2;
    localparam int unsigned CTRL_CCM_BIT  = 7;
    localparam logic [7:0]  CTRL_RESET    = 8'h02;

    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_NEED_BIT = 1;
    localparam logic [1:0]  IRQ_RESET    = 2'h0;

    localparam int unsigned BLOCK_CYCLES = 1000;
    localparam logic [3:0]  LAST_ROUND   = 4'ha;
    localparam logic [7:0]  RCON_FIRST   = 8'h01;

    function automatic logic [7:0] xtime(input logic [7:0] a);
        xtime = {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
    endfunction

    function automatic logic [7:0] inv_xtime(input logic [7:0] a);
        inv_xtime = a[0] ? ({1'b0, a[7:1]} ^ 8'h8d) : {1'b0, a[7:1]};
    endfunction

    function automatic logic [7:0] gmul(input logic [7:0] a, b);
        logic [7:0] p, x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = xtime(x);
        end
        gmul = p;
    endfunction

    function automatic logic [7:0] ginv(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h01;
        for (int i = 7; i >= 0; i--) begin
            r = gmul(r, r);
            if (i != 0) begin
                r = gmul(r, a);
            end
        end
        ginv = r;
    endfunction

    function automatic logic [7:0] rotl8(input logic [7:0] a, input int unsigned n);
        rotl8 = (a << n) | (a >> (8 - n));
    endfunction

    function automatic logic [7:0] sbox(input logic [7:0] a);
        logic [7:0] b;
        b = ginv(a);
        sbox = b ^ rotl8(b, 1) ^ rotl8(b, 2) ^ rotl8(b, 3) ^ rotl8(b, 4) ^ 8'h63;
    endfunction

    function automatic logic [7:0] inv_sbox(input logic [7:0] a);
        inv_sbox = ginv(rotl8(a, 1) ^ rotl8(a, 3) ^ rotl8(a, 6) ^ 8'h05);
    endfunction

    function automatic logic [31:0] sub_rot(input logic [31:0] w, input logic [7:0] rc);
        sub_rot = {sbox(w[23:16]) ^ rc, sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
    endfunction

    function automatic logic [127:0] key_step(input logic [127:0] k, input logic [7:0] rc);
        logic [31:0] n0, n1, n2;
        n0 = k[127:96] ^ sub_rot(k[31:0], rc);
        n1 = k[95:64] ^ n0;
        n2 = k[63:32] ^ n1;
        key_step = {n0, n1, n2, k[31:0] ^ n2};
    endfunction

    function automatic logic [127:0] key_unstep(input logic [127:0] k, input logic [7:0] rc);
        logic [31:0] w3;
        w3 = k[31:0] ^ k[63:32];
        key_unstep = {k[127:96] ^ sub_rot(w3, rc), k[95:64] ^ k[127:96],
                      k[63:32] ^ k[95:64], w3};
    endfunction

    function automatic logic [31:0] swap32(input logic [31:0] w);
        swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

endpackage
`default_nettype wire

// File: bca_round.sv
/*
 One combinational cipher round, forward or inverse.
 Assumes the caller supplies this round's key.
*/
`timescale 1ns/1ps
`default_nettype none
module bca_round (
    // Round data
    input  wire logic [127:0] stateIn,
    input  wire logic [127:0] roundKey,
    output logic      [127:0] stateOut,
    // Round kind
    input  wire logic         decrypt,
    input  wire logic         lastRound
);

    logic [7:0] sb [16];
    logic [7:0] mx [16];

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                if (decrypt) begin
                    sb[4*c+r] = bca_pkg::inv_sbox(stateIn[127-8*(4*((c+4-r)%4)+r) -: 8]);
                end else begin
                    sb[4*c+r] = bca_pkg::sbox(stateIn[127-8*(4*((c+r)%4)+r) -: 8]);
                end
            end
        end
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                if (decrypt) begin
                    mx[4*c+r] = sb[4*c+r] ^ roundKey[127-8*(4*c+r) -: 8];
                end else begin
                    mx[4*c+r] = sb[4*c+r];
                end
            end
        end
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                if (lastRound) begin
                    stateOut[127-8*(4*c+r) -: 8] = mx[4*c+r];
                end else if (decrypt) begin
                    stateOut[127-8*(4*c+r) -: 8] =
                        bca_pkg::gmul(mx[4*c+r], 8'h0e) ^ bca_pkg::gmul(mx[4*c+(r+1)%4], 8'h0b) ^
                        bca_pkg::gmul(mx[4*c+(r+2)%4], 8'h0d) ^ bca_pkg::gmul(mx[4*c+(r+3)%4], 8'h09);
                end else begin
                    stateOut[127-8*(4*c+r) -: 8] =
                        bca_pkg::gmul(mx[4*c+r], 8'h02) ^ bca_pkg::gmul(mx[4*c+(r+1)%4], 8'h03) ^
                        mx[4*c+(r+2)%4] ^ mx[4*c+(r+3)%4];
                end
                if (!decrypt) begin
                    stateOut[127-8*(4*c+r) -: 8] =
                        stateOut[127-8*(4*c+r) -: 8] ^ roundKey[127-8*(4*c+r) -: 8];
                end
            end
        end
    end

endmodule
`default_nettype wire

// File: bca_cipher_top.sv
/*
 Block cipher accelerator: register port, DMA word port, block assembly,
 iterative round engine with key schedule, chaining and interrupt.
 Assumes one clock, synchronous inputs and a master that never waits.
*/
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module bca_cipher_top #(
    parameter int unsigned LATENCY = bca_pkg::BLOCK_CYCLES
) (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       reset_n,
    // Register port
    input  wire logic [bca_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [31:0]                regWdata,
    input  wire logic                       regWrite,
    input  wire logic                       regRead,
    output logic      [31:0]                regRdata,
    // DMA word port
    input  wire logic                       dmaWrite,
    input  wire logic [31:0]                dmaWdata,
    input  wire logic                       dmaRead,
    output logic      [31:0]                dmaRdata,
    output logic                            dmaInReq,
    output logic                            dmaOutReq,
    // Interrupt
    output logic                            irq
);

    localparam int unsigned CW = $clog2(LATENCY + 1);

    typedef enum logic [2:0] {
        FS_IDLE,
        FS_EXPAND,
        FS_ROUND,
        FS_WAIT,
        FS_OUT
    } bca_fsm_type;

    bca_fsm_type    fsmR;
    logic           ctrlDecR;
    logic           ctrlCcmR;
    logic           opDecR;
    logic           opCcmR;
    logic           inNeedR;
    logic           outRdyR;
    logic [127:0]   keyR;
    logic [127:0]   inBlkR;
    logic [127:0]   cipherInR;
    logic [127:0]   stateR;
    logic [127:0]   rkR;
    logic [127:0]   resultR;
    logic [127:0]   chainR;
    logic [7:0]     rconR;
    logic [3:0]     roundR;
    logic [1:0]     wrCntR;
    logic [1:0]     rdCntR;
    logic [CW-1:0]  cycR;
    logic [1:0]     irqStatR;
    logic [1:0]     irqMaskR;
    logic [31:0]    regRdataR;
    logic [31:0]    dmaRdataR;

    logic           busDataWr;
    logic           busDataRd;
    logic           dataWr;
    logic           dataRd;
    logic [31:0]    wrWord;
    logic           take;
    logic           give;
    logic           lastWrite;
    logic           lastRead;
    logic           finish;
    logic [127:0]   fullBlk;
    logic [127:0]   encIn;
    logic [7:0]     rconUse;
    logic [127:0]   rkUse;
    logic [127:0]   roundOut;
    logic           roundLast;
    logic [31:0]    outWord;
    logic [7:0]     ctrlRead;
    logic [1:0]     irqEvent;

    // Access decode; register port wins over DMA
    assign busDataWr = regWrite && (regAddr == bca_pkg::DATA_OFS);
    assign busDataRd = regRead && (regAddr == bca_pkg::DATA_OFS);
    assign dataWr    = busDataWr || dmaWrite;
    assign dataRd    = busDataRd || dmaRead;
    assign wrWord    = busDataWr ? regWdata : dmaWdata;
    assign take      = dataWr && inNeedR;
    assign give      = dataRd && outRdyR;
    assign lastWrite = take && (wrCntR == 2'h3);
    assign lastRead  = give && (rdCntR == 2'h3);
    assign finish    = (fsmR == FS_WAIT) && (cycR == CW'(LATENCY - 1));

    // Block assembly and chaining input
    assign fullBlk = {inBlkR[127:32], bca_pkg::swap32(wrWord)};
    assign encIn   = (ctrlCcmR && !ctrlDecR) ? (fullBlk ^ chainR) : fullBlk;

    // Round key, forward or backward
    assign rconUse   = opDecR ? bca_pkg::inv_xtime(rconR) : rconR;
    assign rkUse     = opDecR ? bca_pkg::key_unstep(rkR, rconUse)
                              : bca_pkg::key_step(rkR, rconUse);
    assign roundLast = (roundR == bca_pkg::LAST_ROUND);

    bca_round bca_round_inst (
        .stateIn   (stateR),
        .roundKey  (rkUse),
        .stateOut  (roundOut),
        .decrypt   (opDecR),
        .lastRound (roundLast)
    );

    assign outWord = bca_pkg::swap32(resultR[7'd127 - {rdCntR, 5'h00} -: 32]);

    // Control register view
    always_comb begin
        ctrlRead                         = 8'h00;
        ctrlRead[bca_pkg::CTRL_DEC_BIT]  = ctrlDecR;
        ctrlRead[bca_pkg::CTRL_NEED_BIT] = inNeedR;
        ctrlRead[bca_pkg::CTRL_RDY_BIT]  = outRdyR;
        ctrlRead[bca_pkg::CTRL_CCM_BIT]  = ctrlCcmR;
    end

    // Software bits; status bits ignore writes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlDecR <= bca_pkg::CTRL_RESET[bca_pkg::CTRL_DEC_BIT];
            ctrlCcmR <= bca_pkg::CTRL_RESET[bca_pkg::CTRL_CCM_BIT];
        end else if (regWrite && (regAddr == bca_pkg::CTRL_OFS)) begin
            ctrlDecR <= regWdata[bca_pkg::CTRL_DEC_BIT];
            ctrlCcmR <= regWdata[bca_pkg::CTRL_CCM_BIT];
        end
    end

    // Key register, one word per aligned address
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            keyR <= 128'h0;
        end else if (regWrite && (regAddr[11:4] == bca_pkg::KEY_OFS[11:4])) begin
            keyR[7'd127 - {regAddr[3:2], 5'h00} -: 32] <= bca_pkg::swap32(regWdata);
        end
    end

    // Input needed flag
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            inNeedR <= bca_pkg::CTRL_RESET[bca_pkg::CTRL_NEED_BIT];
        end else if (lastWrite) begin
            inNeedR <= 1'b0;
        end else if (lastRead) begin
            inNeedR <= 1'b1;
        end
    end

    // Output ready flag
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            outRdyR <= bca_pkg::CTRL_RESET[bca_pkg::CTRL_RDY_BIT];
        end else if (finish) begin
            outRdyR <= 1'b1;
        end else if (lastRead) begin
            outRdyR <= 1'b0;
        end
    end

    // Word counters of the data port
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrCntR <= 2'h0;
            rdCntR <= 2'h0;
        end else begin
            if (take) begin
                wrCntR <= wrCntR + 2'h1;
            end
            if (give) begin
                rdCntR <= rdCntR + 2'h1;
            end
        end
    end

    // Input words 0 to 3
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            inBlkR <= 128'h0;
        end else if (take) begin
            inBlkR[7'd127 - {wrCntR, 5'h00} -: 32] <= bca_pkg::swap32(wrWord);
        end
    end

    // Sequencer and round engine
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fsmR      <= FS_IDLE;
            opDecR    <= 1'b0;
            opCcmR    <= 1'b0;
            stateR    <= 128'h0;
            rkR       <= 128'h0;
            rconR     <= bca_pkg::RCON_FIRST;
            roundR    <= 4'h0;
            cipherInR <= 128'h0;
        end else begin
            case (fsmR)
                FS_IDLE: begin
                    if (lastWrite) begin
                        opDecR    <= ctrlDecR;
                        opCcmR    <= ctrlCcmR;
                        rkR       <= keyR;
                        rconR     <= bca_pkg::RCON_FIRST;
                        cipherInR <= fullBlk;
                        if (ctrlDecR) begin
                            stateR <= fullBlk;
                            roundR <= 4'h0;
                            fsmR   <= FS_EXPAND;
                        end else begin
                            stateR <= encIn ^ keyR;
                            roundR <= 4'h1;
                            fsmR   <= FS_ROUND;
                        end
                    end
                end
                FS_EXPAND: begin
                    rkR    <= bca_pkg::key_step(rkR, rconR);
                    rconR  <= bca_pkg::xtime(rconR);
                    roundR <= roundR + 4'h1;
                    if (roundR == bca_pkg::LAST_ROUND - 4'h1) begin
                        stateR <= stateR ^ bca_pkg::key_step(rkR, rconR);
                        roundR <= 4'h1;
                        fsmR   <= FS_ROUND;
                    end
                end
                FS_ROUND: begin
                    rkR    <= rkUse;
                    rconR  <= opDecR ? rconUse : bca_pkg::xtime(rconR);
                    roundR <= roundR + 4'h1;
                    stateR <= roundOut;
                    if (roundLast) begin
                        if (opDecR && opCcmR) begin
                            stateR <= roundOut ^ chainR;
                        end
                        fsmR <= FS_WAIT;
                    end
                end
                FS_WAIT: begin
                    if (finish) begin
                        fsmR <= FS_OUT;
                    end
                end
                FS_OUT: begin
                    if (lastRead) begin
                        fsmR <= FS_IDLE;
                    end
                end
                default: begin
                    fsmR <= FS_IDLE;
                end
            endcase
        end
    end

    // Cycle count from the fourth input word
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cycR <= '0;
        end else if (lastWrite) begin
            cycR <= '0;
        end else if (fsmR != FS_IDLE && fsmR != FS_OUT && !finish) begin
            cycR <= cycR + 1'b1;
        end
    end

    // Result and chaining value
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            resultR <= 128'h0;
            chainR  <= 128'h0;
        end else begin
            if (finish) begin
                resultR <= stateR;
            end
            if (!ctrlCcmR) begin
                chainR <= 128'h0;
            end else if (finish) begin
                chainR <= opDecR ? cipherInR : stateR;
            end
        end
    end

    // Interrupt status: set wins over clear-on-read
    always_comb begin
        irqEvent                        = 2'h0;
        irqEvent[bca_pkg::IRQ_DONE_BIT] = finish;
        irqEvent[bca_pkg::IRQ_NEED_BIT] = lastRead;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqStatR <= bca_pkg::IRQ_RESET;
        end else if (regRead && (regAddr == bca_pkg::IRQ_STAT_OFS)) begin
            irqStatR <= irqEvent;
        end else begin
            irqStatR <= irqStatR | irqEvent;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqMaskR <= bca_pkg::IRQ_RESET;
        end else if (regWrite && (regAddr == bca_pkg::IRQ_MASK_OFS)) begin
            irqMaskR <= regWdata[1:0];
        end
    end

    assign irq = |(irqStatR & irqMaskR);

    // Register read data
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdataR <= 32'h0;
        end else if (regRead) begin
            regRdataR <= 32'h0;
            if (regAddr == bca_pkg::CTRL_OFS) begin
                regRdataR <= {24'h0, ctrlRead};
            end else if (regAddr == bca_pkg::DATA_OFS) begin
                regRdataR <= outRdyR ? outWord : 32'h0;
            end else if (regAddr[11:4] == bca_pkg::KEY_OFS[11:4]) begin
                regRdataR <= bca_pkg::swap32(keyR[7'd127 - {regAddr[3:2], 5'h00} -: 32]);
            end else if (regAddr == bca_pkg::IRQ_STAT_OFS) begin
                regRdataR <= {30'h0, irqStatR};
            end else if (regAddr == bca_pkg::IRQ_MASK_OFS) begin
                regRdataR <= {30'h0, irqMaskR};
            end
        end
    end

    // DMA read data
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dmaRdataR <= 32'h0;
        end else if (dmaRead && !busDataRd) begin
            dmaRdataR <= outRdyR ? outWord : 32'h0;
        end
    end

    assign regRdata  = regRdataR;
    assign dmaRdata  = dmaRdataR;
    assign dmaInReq  = inNeedR;
    assign dmaOutReq = outRdyR;

endmodule
`default_nettype wire

// File: bca_cipher_asserts.sv
/* Port checker of the cipher accelerator.
 Assumes a bind to the top module. */
`timescale 1ns/1ps
`default_nettype none
module bca_cipher_asserts #(
    parameter int unsigned LATENCY = 1000
) (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [11:0] regAddr,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    input wire logic        dmaWrite,
    input wire logic        dmaRead,
    input wire logic        dmaInReq,
    input wire logic        dmaOutReq
);
    logic [31:0] busyCnt;
    logic        dataRd;
    logic        dataWr;
    assign dataRd = dmaRead || (regRead && regAddr == bca_pkg::DATA_OFS);
    assign dataWr = dmaWrite || (regWrite && regAddr == bca_pkg::DATA_OFS);
    // Cycles between input taken and result ready
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            busyCnt <= 32'h0;
        end else if (!dmaInReq && !dmaOutReq) begin
            busyCnt <= busyCnt + 32'h1;
        end else begin
            busyCnt <= 32'h0;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence rearmSeq;
        $past(dataRd) ##0 dmaInReq;
    endsequence
    sequence ctrlReadSeq;
        regRead && regAddr == bca_pkg::CTRL_OFS;
    endsequence
    AST_LATENCY: assert property ($rose(dmaOutReq) |-> busyCnt == LATENCY)
        else $error("result ready at wrong cycle");
    AST_NOSTALL: assert property (busyCnt <= LATENCY)
        else $error("operation overran its latency");
    AST_EXCL: assert property (!(dmaInReq && dmaOutReq))
        else $error("input and output ready together");
    AST_CTRL: assert property (ctrlReadSeq |=> regRdata[2:1] == $past({dmaOutReq, dmaInReq}))
        else $error("control status bits wrong");
    AST_INHOLD: assert property (!dmaInReq && !dmaOutReq |=> !dmaInReq)
        else $error("input wanted during operation");
    AST_OUTHOLD: assert property (dmaOutReq && !dataRd |=> dmaOutReq)
        else $error("output ready dropped without read");
    AST_OUTCLR: assert property ($fell(dmaOutReq) |-> rearmSeq)
        else $error("output drain did not rearm input");
    AST_INCLR: assert property ($fell(dmaInReq) |-> $past(dataWr))
        else $error("input bit cleared without write");
    AST_IDLERD: assert property (regRead && regAddr == bca_pkg::DATA_OFS && !dmaOutReq
        |=> regRdata == 32'h0)
        else $error("data read while not ready");
endmodule
bind bca_cipher_top bca_cipher_asserts #(.LATENCY(LATENCY)) bca_cipher_asserts_inst (
    .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .dmaWrite(dmaWrite), .dmaRead(dmaRead),
    .dmaInReq(dmaInReq), .dmaOutReq(dmaOutReq));
`default_nettype wire

// File: bca_dma_model.sv
/* DMA engine model: one block in, result out.
 Assumes key and direction set beforehand. */
`timescale 1ns/1ps
`default_nettype none
module bca_dma_model (
    input  wire logic         core_clk,
    input  wire logic         start,
    input  wire logic         slow,
    input  wire logic [127:0] src,
    input  wire logic         dmaInReq,
    input  wire logic         dmaOutReq,
    input  wire logic [31:0]  dmaRdata,
    output logic              dmaWrite,
    output logic              dmaRead,
    output logic       [31:0] dmaWdata,
    output logic      [127:0] result,
    output logic              done
);
    initial begin
        dmaWrite = 1'b0;
        dmaRead  = 1'b0;
        dmaWdata = 32'h0;
        result   = 128'h0;
        done     = 1'b0;
    end
    // Data only, no configuration
    always begin
        @(posedge core_clk);
        if (start === 1'b1) begin
            done <= 1'b0;
            while (dmaInReq !== 1'b1) @(posedge core_clk);
            for (int k = 0; k < 4; k++) begin
                dmaWrite <= 1'b1;
                dmaWdata <= src[32*k+:32];
                @(posedge core_clk);
                if (slow) begin
                    dmaWrite <= 1'b0;
                    dmaWdata <= ~src[32*k+:32];
                    @(posedge core_clk);
                end
            end
            dmaWrite <= 1'b0;
            dmaWdata <= ~src[127:96];
            while (dmaOutReq !== 1'b1) @(posedge core_clk);
            for (int k = 0; k < 4; k++) begin
                dmaRead <= 1'b1;
                @(posedge core_clk);
                dmaRead <= 1'b0;
                #1 result[32*k+:32] = dmaRdata;
                if (slow) @(posedge core_clk);
            end
            done <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: tb_bca_cipher_top.sv
/* Bench of the cipher accelerator.
 Assumes the bound checker and the DMA model. */
`timescale 1ns/1ps
`default_nettype none
module tb_bca_cipher_top;
    localparam int unsigned LAT = 32;
    localparam logic [127:0] PT = 128'hffeeddcc_bbaa9988_77665544_33221100;
    localparam logic [127:0] CT = 128'h5ac5b470_80b7cdd8_30047b6a_d8e0c469;
    localparam logic [127:0] KY = 128'h0f0e0d0c_0b0a0908_07060504_03020100;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic dmaStart = 1'b0;
    logic dmaSlow = 1'b0;
    logic [127:0] dmaSrc = 128'h0;
    logic [31:0] regRdata, dmaWdata, dmaRdata;
    logic dmaWrite, dmaRead, dmaInReq, dmaOutReq, irq, dmaDone;
    logic [127:0] dmaResult;
    int errCount = 0;
    int cmpCount = 0;
    always #50 core_clk = ~core_clk;
    bca_cipher_top #(.LATENCY(LAT)) bca_cipher_top_inst (
        .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .dmaWrite(dmaWrite),
        .dmaWdata(dmaWdata), .dmaRead(dmaRead), .dmaRdata(dmaRdata), .dmaInReq(dmaInReq),
        .dmaOutReq(dmaOutReq), .irq(irq));
    bca_dma_model bca_dma_model_inst (
        .core_clk(core_clk), .start(dmaStart), .slow(dmaSlow), .src(dmaSrc),
        .dmaInReq(dmaInReq), .dmaOutReq(dmaOutReq), .dmaRdata(dmaRdata),
        .dmaWrite(dmaWrite), .dmaRead(dmaRead), .dmaWdata(dmaWdata),
        .result(dmaResult), .done(dmaDone));
    task automatic chk(input string name, input logic [127:0] exp, got);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic runBlock(input logic [7:0] c, input logic [127:0] din, exp,
                            input logic irqExp);
        logic [31:0]  d;
        logic [127:0] res;
        wr(bca_pkg::CTRL_OFS, {24'h0, c});
        for (int k = 0; k < 4; k++) wr(bca_pkg::DATA_OFS, din[32*k+:32]);
        rd(bca_pkg::CTRL_OFS, d);
        chk("input wanted", 1'b0, d[1]);
        for (int n = 0; n < LAT + 20 && dmaOutReq !== 1'b1; n++) @(posedge core_clk);
        rd(bca_pkg::CTRL_OFS, d);
        chk("ctrl at done", {c[7], 4'h0, 2'b10, c[0]}, d[7:0]);
        chk("irq", irqExp, irq);
        for (int k = 0; k < 4; k++) begin
            rd(bca_pkg::DATA_OFS, d);
            res[32*k+:32] = d;
        end
        chk("result", exp, res);
        rd(bca_pkg::CTRL_OFS, d);
        chk("ctrl drained", {c[7], 4'h0, 2'b01, c[0]}, d[7:0]);
    endtask
    task automatic tResetAndMap;
        logic [31:0] d;
        rd(bca_pkg::CTRL_OFS, d);
        chk("ctrl reset", bca_pkg::CTRL_RESET, d);
        rd(bca_pkg::KEY_OFS, d);
        chk("key reset", 32'h0, d);
        rd(bca_pkg::IRQ_MASK_OFS, d);
        chk("mask reset", 32'h0, d);
        rd(12'h7f0, d);
        chk("unmapped", 32'h0, d);
        rd(bca_pkg::DATA_OFS, d);
        chk("idle data", 32'h0, d);
        wr(bca_pkg::CTRL_OFS, 32'h06);
        rd(bca_pkg::CTRL_OFS, d);
        chk("ctrl read-only", 32'h02, d);
        for (int k = 0; k < 4; k++) wr(bca_pkg::KEY_OFS + 12'(4 * k), KY[32*k+:32]);
        rd(bca_pkg::KEY_OFS + 12'h00c, d);
        chk("key readback", KY[127:96], d);
    endtask
    task automatic tDma;
        wr(bca_pkg::CTRL_OFS, 32'h01);
        dmaSrc   <= CT;
        dmaSlow  <= 1'b1;
        dmaStart <= 1'b1;
        @(posedge core_clk);
        dmaStart <= 1'b0;
        for (int n = 0; n < LAT + 40 && dmaDone !== 1'b1; n++) @(posedge core_clk);
        chk("dma result", PT, dmaResult);
    endtask
    task automatic tIrq;
        logic [31:0] d;
        rd(bca_pkg::IRQ_STAT_OFS, d);
        wr(bca_pkg::IRQ_MASK_OFS, 32'h1);
        runBlock(8'h00, PT, CT, 1'b1);
        rd(bca_pkg::IRQ_STAT_OFS, d);
        chk("status", 2'b11, d[1:0]);
        chk("irq cleared", 1'b0, irq);
        wr(bca_pkg::IRQ_MASK_OFS, 32'h0);
    endtask
    task automatic printVerdict;
        $display("comparisons %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errCount++;
        printVerdict();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        tResetAndMap();
        runBlock(8'h00, PT, CT, 1'b0);
        runBlock(8'h01, CT, PT, 1'b0);
        runBlock(8'h00, PT, CT, 1'b0);
        runBlock(8'h80, PT, CT, 1'b0);
        runBlock(8'h81, CT, PT ^ CT, 1'b0);
        runBlock(8'h00, PT, CT, 1'b0);
        tIrq();
        tDma();
        printVerdict();
    end
endmodule
`default_nettype wire
